// *** verilog/ctmw_pkg.sv ***
// Shared constants and types for the CAN timer and mailbox window
package ctmw_pkg;

  // Special-function-register addresses
  localparam logic [7:0] ADDR_TIMER_PRESCALE = 8'hA1;
  localparam logic [7:0] ADDR_MAILBOX_DATA = 8'hA3;
  localparam logic [7:0] ADDR_TRIGGER_LOW = 8'hA4;
  localparam logic [7:0] ADDR_TRIGGER_HIGH = 8'hA5;
  localparam logic [7:0] ADDR_MSG_TIMER_LOW = 8'hAC;
  localparam logic [7:0] ADDR_MSG_TIMER_HIGH = 8'hAD;
  localparam logic [7:0] ADDR_STAMP_LOW = 8'hAE;
  localparam logic [7:0] ADDR_STAMP_HIGH = 8'hAF;

  // Values after reset, and the read value of unmapped addresses
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] PRESC_CNT_RST = 8'h00;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [7:0] TRIGGER_LOW_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [2:0] PTR_RST = 3'h0;

  // Mailbox geometry: 15 message objects of 8 bytes each
  localparam int MBX_OBJECTS = 15;
  localparam int MBX_BYTES = 8;
  localparam int MBX_ENTRIES = MBX_OBJECTS * MBX_BYTES;

  // One register access from the core, all in the same clock domain
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ctmw_sfr_req_t;

endpackage : ctmw_pkg

// *** verilog/ctmw_mailbox.sv ***
// Mailbox byte store for all message objects with its cyclic byte pointer
`timescale 1ns/1ps

module ctmw_mailbox
  import ctmw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] mob_sel,
  input wire logic ptr_load,
  input wire logic [2:0] ptr_value,
  input wire logic auto_inc_en,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [2:0] ptr_q
);

  logic [2:0] ptr_d;
  logic [7:0] store_q [MBX_ENTRIES];
  logic [6:0] index;
  logic obj_valid;

  // Flat index of the selected byte; object 15 does not exist
  assign obj_valid = (mob_sel < 4'(MBX_OBJECTS));
  assign index = {mob_sel, ptr_q};

  // Read returns zero for the missing object rather than stale data
  assign rdata = obj_valid ? store_q[index] : 8'h00;

  // Pointer: a page load wins over the increment of the same cycle
  always_comb
  begin
    ptr_d = ptr_q;
    if (ptr_load)
    begin
      ptr_d = ptr_value;
    end
    else if (auto_inc_en && (acc_wr || acc_rd))
    begin
      ptr_d = 3'(ptr_q + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_q <= PTR_RST;
    end
    else
    begin
      ptr_q <= ptr_d;
    end
  end

  // Storage carries no reset: mailbox content is undefined at power-up
  for (genvar e = 0; e < MBX_ENTRIES; e++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (acc_wr && obj_valid && (index == 7'(e)))
      begin
        store_q[e] <= wdata;
      end
    end
  end

  // Each data access under auto-increment without a page load steps the pointer, wrapping 7 to 0
  chk_ptr_wrap_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    (auto_inc_en && (acc_wr || acc_rd) && !ptr_load) |=> ptr_q == 3'($past(ptr_q) + 3'h1))
    else $error("mailbox pointer did not advance by one");

  // Without auto-increment the pointer only moves on a page load
  chk_ptr_hold_noinc: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!auto_inc_en && !ptr_load) |=> $stable(ptr_q))
    else $error("mailbox pointer moved without auto-increment");

endmodule : ctmw_mailbox

// *** verilog/ctmw_top.sv ***
// CAN timer, stamp, trigger timer and mailbox data window in SFR space
`timescale 1ns/1ps

module ctmw_top
  import ctmw_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire ctmw_sfr_req_t SFR_REQ,
  input wire logic [3:0] MOB_SEL,
  input wire logic PTR_LOAD,
  input wire logic [2:0] PTR_VALUE,
  input wire logic AUTO_INC_EN,
  input wire logic STAMP_EVT,
  input wire logic TTC_EVT,
  output logic [7:0] SFR_RDATA,
  output logic [15:0] TIMER_COUNT,
  output logic [2:0] MBX_PTR
);

  // Register state
  logic [7:0] prescale_value_q;
  logic [7:0] prescale_value_d;
  logic [7:0] presc_cnt_q;
  logic [7:0] presc_cnt_d;
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  logic [7:0] trigger_low_q;
  logic [7:0] trigger_low_d;
  logic [7:0] trigger_high_q;
  logic [7:0] trigger_high_d;
  logic [15:0] stamp_q;
  logic [15:0] stamp_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Decode and mailbox wiring
  logic wr_prescale;
  logic wr_tim_low;
  logic wr_tim_high;
  logic mbx_wr;
  logic mbx_rd;
  logic tick;
  logic [7:0] mbx_rdata;
  logic [2:0] mbx_ptr_q;

  // Write strobes per register; read-only addresses have no strobe at all
  assign wr_prescale = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER_PRESCALE);
  assign wr_tim_low = SFR_REQ.wr && (SFR_REQ.addr == ADDR_MSG_TIMER_LOW);
  assign wr_tim_high = SFR_REQ.wr && (SFR_REQ.addr == ADDR_MSG_TIMER_HIGH);
  assign mbx_wr = SFR_REQ.wr && (SFR_REQ.addr == ADDR_MAILBOX_DATA);
  assign mbx_rd = SFR_REQ.rd && (SFR_REQ.addr == ADDR_MAILBOX_DATA);

  // Prescaler terminal count; >= keeps counting sane when the value is lowered
  assign tick = (presc_cnt_q >= prescale_value_q);

  ctmw_mailbox u_mailbox (
    .clk (SYS_CLK),
    .rst_n (RST_N),
    .mob_sel (MOB_SEL),
    .ptr_load (PTR_LOAD),
    .ptr_value (PTR_VALUE),
    .auto_inc_en (AUTO_INC_EN),
    .acc_wr (mbx_wr),
    .acc_rd (mbx_rd),
    .wdata (SFR_REQ.wdata),
    .rdata (mbx_rdata),
    .ptr_q (mbx_ptr_q)
  );

  // Prescaler register next value
  always_comb
  begin
    prescale_value_d = prescale_value_q;
    if (wr_prescale)
    begin
      prescale_value_d = SFR_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prescale_value_q <= PRESCALE_RST;
    end
    else
    begin
      prescale_value_q <= prescale_value_d;
    end
  end

  // Timer: divide by prescale+1, then a software byte write overrides the count
  always_comb
  begin
    presc_cnt_d = presc_cnt_q;
    timer_d = timer_q;
    if (tick)
    begin
      presc_cnt_d = PRESC_CNT_RST;
      timer_d = timer_q + 16'h0001;
    end
    else
    begin
      presc_cnt_d = presc_cnt_q + 8'h01;
    end
    if (wr_tim_low)
    begin
      timer_d[7:0] = SFR_REQ.wdata;
    end
    if (wr_tim_high)
    begin
      timer_d[15:8] = SFR_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      presc_cnt_q <= PRESC_CNT_RST;
      timer_q <= TIMER_RST;
    end
    else
    begin
      presc_cnt_q <= presc_cnt_d;
      timer_q <= timer_d;
    end
  end

  // Trigger timer low byte captures the count on a trigger event
  always_comb
  begin
    trigger_low_d = trigger_low_q;
    if (TTC_EVT)
    begin
      trigger_low_d = timer_q[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      trigger_low_q <= TRIGGER_LOW_RST;
    end
    else
    begin
      trigger_low_q <= trigger_low_d;
    end
  end

  // High trigger byte and stamp capture the running count on their events
  always_comb
  begin
    trigger_high_d = trigger_high_q;
    stamp_d = stamp_q;
    if (TTC_EVT)
    begin
      trigger_high_d = timer_q[15:8];
    end
    if (STAMP_EVT)
    begin
      stamp_d = timer_q;
    end
  end

  // No reset here: software must wait for an event before trusting them
  always_ff @(posedge SYS_CLK)
  begin
    trigger_high_q <= trigger_high_d;
    stamp_q <= stamp_d;
  end

  // Read data mux; the answer is registered and holds until the next read
  always_comb
  begin
    rdata_d = rdata_q;
    if (SFR_REQ.rd)
    begin
      if (SFR_REQ.addr == ADDR_TIMER_PRESCALE)
      begin
        rdata_d = prescale_value_q;
      end
      else if (SFR_REQ.addr == ADDR_MAILBOX_DATA)
      begin
        rdata_d = mbx_rdata;
      end
      else if (SFR_REQ.addr == ADDR_TRIGGER_LOW)
      begin
        rdata_d = trigger_low_q;
      end
      else if (SFR_REQ.addr == ADDR_TRIGGER_HIGH)
      begin
        rdata_d = trigger_high_q;
      end
      else if (SFR_REQ.addr == ADDR_MSG_TIMER_LOW)
      begin
        rdata_d = timer_q[7:0];
      end
      else if (SFR_REQ.addr == ADDR_MSG_TIMER_HIGH)
      begin
        rdata_d = timer_q[15:8];
      end
      else if (SFR_REQ.addr == ADDR_STAMP_LOW)
      begin
        rdata_d = stamp_q[7:0];
      end
      else if (SFR_REQ.addr == ADDR_STAMP_HIGH)
      begin
        rdata_d = stamp_q[15:8];
      end
      else
      begin
        rdata_d = UNMAPPED_RDATA;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign SFR_RDATA = rdata_q;
  assign TIMER_COUNT = timer_q;
  assign MBX_PTR = mbx_ptr_q;

  // A mailbox read returns the byte under the pointer at the read edge
  chk_mbx_read_byte: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    mbx_rd |=> SFR_RDATA == $past(mbx_rdata))
    else $error("mailbox read returned the wrong byte");

  // Between ticks the timer holds; on a tick it steps by exactly one
  chk_presc_hold: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (!tick && !wr_tim_low && !wr_tim_high) |=> timer_q == $past(timer_q))
    else $error("timer moved before prescaler terminal count");

  chk_presc_step: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (tick && !wr_tim_low && !wr_tim_high) |=> timer_q == $past(timer_q) + 16'h0001)
    else $error("timer did not step on prescaler terminal count");

  // Prescaler reads zero while reset is asserted
  chk_presc_reset: assert property (
    @(posedge SYS_CLK)
    !RST_N |-> (prescale_value_q == PRESCALE_RST) && (timer_q == TIMER_RST))
    else $error("prescaler or timer not zero under reset");

  // High and low timer bytes answer at their own addresses
  chk_timer_high_read: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (SFR_REQ.rd && SFR_REQ.addr == ADDR_MSG_TIMER_HIGH) |=> SFR_RDATA == $past(timer_q[15:8]))
    else $error("timer high byte read wrong");

  chk_timer_low_read: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (SFR_REQ.rd && SFR_REQ.addr == ADDR_MSG_TIMER_LOW) |=> SFR_RDATA == $past(timer_q[7:0]))
    else $error("timer low byte read wrong");

  // Software writes to the stamp leave it untouched
  chk_stamp_readonly: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (SFR_REQ.wr && !STAMP_EVT) |=> $stable(stamp_q))
    else $error("stamp changed without a capture event");

  // A stamp event captures the running count
  chk_stamp_capture: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    STAMP_EVT |=> stamp_q == $past(timer_q))
    else $error("stamp did not capture the timer");

  // Trigger timer: low byte zero under reset, full count captured on event
  chk_trig_reset: assert property (
    @(posedge SYS_CLK)
    !RST_N |-> trigger_low_q == TRIGGER_LOW_RST)
    else $error("trigger low byte not zero under reset");

  // Two quiet cycles after an event the captured count is still held
  chk_trig_capture: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    TTC_EVT ##1 !TTC_EVT [*2] |-> {trigger_high_q, trigger_low_q} == $past(timer_q, 2))
    else $error("trigger timer lost its captured count");

endmodule : ctmw_top

// *** verification/ctmw_top_bench.sv ***
// Self-checking bench for the CAN timer, stamp, trigger timer and mailbox window
`timescale 1ns/1ps

module ctmw_top_bench
  import ctmw_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  ctmw_sfr_req_t sfr_req;
  logic [3:0] mob_sel;
  logic ptr_load;
  logic [2:0] ptr_value;
  logic auto_inc_en;
  logic stamp_evt;
  logic ttc_evt;
  logic [7:0] sfr_rdata;
  logic [15:0] timer_count;
  logic [2:0] mbx_ptr;
  logic [7:0] rd_val;
  logic [15:0] t0;
  int fail_count;
  int n_tests;

  // One register case: write a value, read it back, expect a value
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } ctmw_row_t;

  ctmw_row_t rows [5] = '{
    '{8'hA1, 8'h5A, 8'h5A},
    '{8'hA1, 8'hC3, 8'hC3},
    '{8'hA4, 8'hFF, 8'h00},
    '{8'h10, 8'h77, 8'h00},
    '{8'hA2, 8'h55, 8'h00}
  };
  int presc [3] = '{0, 3, 255};

  ctmw_top u_dut (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .SFR_REQ(sfr_req),
    .MOB_SEL(mob_sel),
    .PTR_LOAD(ptr_load),
    .PTR_VALUE(ptr_value),
    .AUTO_INC_EN(auto_inc_en),
    .STAMP_EVT(stamp_evt),
    .TTC_EVT(ttc_evt),
    .SFR_RDATA(sfr_rdata),
    .TIMER_COUNT(timer_count),
    .MBX_PTR(mbx_ptr)
  );

  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check

  // One access per call; the idle cycle after it keeps drivers from colliding
  task automatic sfr_access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
    @(negedge sys_clk);
    sfr_req = '{addr: addr, wdata: data, wr: wr, rd: !wr};
    @(negedge sys_clk);
    sfr_req = '0;
    rd_val = sfr_rdata;
  endtask : sfr_access

  task automatic load_ptr(input logic [3:0] obj, input logic [2:0] val, input logic inc);
    @(negedge sys_clk);
    mob_sel = obj;
    auto_inc_en = inc;
    ptr_value = val;
    ptr_load = 1'b1;
    @(negedge sys_clk);
    ptr_load = 1'b0;
  endtask : load_ptr

  // Bounded wait for the timer to step, so later counts start on a tick
  task automatic wait_tick();
    int i;
    i = 0;
    t0 = timer_count;
    while (timer_count === t0 && i < 600)
    begin
      @(negedge sys_clk);
      i++;
    end
    check("tick_seen", 16'h0001, {15'h0000, i < 600});
    t0 = timer_count;
  endtask : wait_tick

  // Watchdog well above the expected run of about 1200 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    fail_count = 0;
    n_tests = 0;
    rst_n = 1'b1;
    sfr_req = '0;
    mob_sel = 4'h0;
    ptr_load = 1'b0;
    ptr_value = 3'h0;
    auto_inc_en = 1'b0;
    stamp_evt = 1'b0;
    ttc_evt = 1'b0;
    // Drop reset on a clean edge so every flop sees it, not a time-zero race
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    check("timer_rst", 16'h0000, timer_count);
    check("ptr_rst", 16'h0000, {13'h0000, mbx_ptr});
    rst_n = 1'b1;
    sfr_access(ADDR_TIMER_PRESCALE, 8'h00, 1'b0);
    check("prescale_rst", 16'h0000, {8'h00, rd_val});
    sfr_access(ADDR_TRIGGER_LOW, 8'h00, 1'b0);
    check("trigger_low_rst", 16'h0000, {8'h00, rd_val});
    // Capture once so the stamp holds a defined value before any write
    @(negedge sys_clk);
    stamp_evt = 1'b1;
    @(negedge sys_clk);
    stamp_evt = 1'b0;
    $display("test reset done");
    foreach (rows[k])
    begin
      sfr_access(rows[k].addr, rows[k].wdata, 1'b1);
      sfr_access(rows[k].addr, 8'h00, 1'b0);
      check("row_readback", {8'h00, rows[k].exp}, {8'h00, rd_val});
    end
    $display("test register rows done");
    // Two timer steps must take exactly two prescaler periods
    foreach (presc[k])
    begin
      sfr_access(ADDR_TIMER_PRESCALE, presc[k][7:0], 1'b1);
      wait_tick();
      repeat ((presc[k] + 1) * 2) @(negedge sys_clk);
      check("timer_rate", t0 + 16'h0002, timer_count);
    end
    $display("test prescale rates done");
    // Prescale is 255 now, so the next steps all fit between two ticks
    wait_tick();
    sfr_access(ADDR_MSG_TIMER_LOW, 8'h34, 1'b1);
    sfr_access(ADDR_MSG_TIMER_HIGH, 8'h12, 1'b1);
    check("timer_loaded", 16'h1234, timer_count);
    sfr_access(ADDR_MSG_TIMER_LOW, 8'h00, 1'b0);
    check("timer_low", 16'h0034, {8'h00, rd_val});
    sfr_access(ADDR_MSG_TIMER_HIGH, 8'h00, 1'b0);
    check("timer_high", 16'h0012, {8'h00, rd_val});
    @(negedge sys_clk);
    stamp_evt = 1'b1;
    ttc_evt = 1'b1;
    @(negedge sys_clk);
    stamp_evt = 1'b0;
    ttc_evt = 1'b0;
    sfr_access(ADDR_STAMP_LOW, 8'h00, 1'b1);
    sfr_access(ADDR_STAMP_HIGH, 8'h00, 1'b1);
    sfr_access(ADDR_TRIGGER_HIGH, 8'h00, 1'b1);
    sfr_access(ADDR_STAMP_LOW, 8'h00, 1'b0);
    check("stamp_low", 16'h0034, {8'h00, rd_val});
    sfr_access(ADDR_STAMP_HIGH, 8'h00, 1'b0);
    check("stamp_high", 16'h0012, {8'h00, rd_val});
    sfr_access(ADDR_TRIGGER_LOW, 8'h00, 1'b0);
    check("trigger_low", 16'h0034, {8'h00, rd_val});
    sfr_access(ADDR_TRIGGER_HIGH, 8'h00, 1'b0);
    check("trigger_high", 16'h0012, {8'h00, rd_val});
    $display("test timer bytes and capture done");
    // Start near the end of the buffer so the pointer has to wrap
    load_ptr(4'h2, 3'h6, 1'b1);
    for (int i = 0; i < 3; i++)
      sfr_access(ADDR_MAILBOX_DATA, 8'hA0 + 8'(i), 1'b1);
    check("ptr_wrap", 16'h0001, {13'h0000, mbx_ptr});
    load_ptr(4'h3, 3'h6, 1'b1);
    sfr_access(ADDR_MAILBOX_DATA, 8'h55, 1'b1);
    load_ptr(4'h2, 3'h6, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      sfr_access(ADDR_MAILBOX_DATA, 8'h00, 1'b0);
      check("mbx_read", {8'h00, 8'hA0 + 8'(i)}, {8'h00, rd_val});
    end
    load_ptr(4'h2, 3'h7, 1'b0);
    sfr_access(ADDR_MAILBOX_DATA, 8'h00, 1'b0);
    sfr_access(ADDR_MAILBOX_DATA, 8'h00, 1'b0);
    check("mbx_no_inc", 16'h00A1, {8'h00, rd_val});
    check("ptr_held", 16'h0007, {13'h0000, mbx_ptr});
    load_ptr(4'hF, 3'h0, 1'b0);
    sfr_access(ADDR_MAILBOX_DATA, 8'h00, 1'b0);
    check("mbx_absent", 16'h0000, {8'h00, rd_val});
    $display("test mailbox done");
    // Reset in mid-run must restore prescaler, timer and pointer
    sfr_access(ADDR_TIMER_PRESCALE, 8'h07, 1'b1);
    @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    check("timer_rerst", 16'h0000, timer_count);
    check("ptr_rerst", 16'h0000, {13'h0000, mbx_ptr});
    rst_n = 1'b1;
    sfr_access(ADDR_TIMER_PRESCALE, 8'h00, 1'b0);
    check("prescale_rerst", 16'h0000, {8'h00, rd_val});
    sfr_access(ADDR_TRIGGER_LOW, 8'h00, 1'b0);
    check("trigger_low_rerst", 16'h0000, {8'h00, rd_val});
    $display("test mid-run reset done");
    print_verdict();
  end

endmodule : ctmw_top_bench
